// ==== core/spi_baud_gen.sv ====
// baud divider: half-period counter that toggles the serial clock
module spi_baud_gen (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic run_in,
    input wire logic [2:0] prescale_in,
    input wire logic [2:0] rate_in,
    output logic [spi_cfg_pkg::DIV_BITS-1:0] divisor_out,
    output logic sck_out,
    output logic edge_out
);
    logic [spi_cfg_pkg::DIV_BITS-1:0] count;
    logic [spi_cfg_pkg::DIV_BITS-1:0] half;

    function automatic logic [spi_cfg_pkg::DIV_BITS-1:0] calc_div(input logic [2:0] p,
                                                                  input logic [2:0] r);
        logic [spi_cfg_pkg::DIV_BITS-1:0] base;
        base = {{(spi_cfg_pkg::DIV_BITS-3){1'b0}}, p} + 12'h001;
        calc_div = base << ({1'b0, r} + 4'h1);
    endfunction

    assign divisor_out = calc_div(prescale_in, rate_in);
    assign half = {1'b0, divisor_out[spi_cfg_pkg::DIV_BITS-1:1]};
    assign edge_out = run_in && (count == half - 12'h001);

    // half-divisor toggling gives a bit period equal to the whole divisor
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || !run_in) begin
            count <= 12'h000;
            sck_out <= 1'b0;
        end else if (edge_out) begin
            count <= 12'h000;
            sck_out <= ~sck_out;
        end else begin
            count <= count + 12'h001;
        end
    end

    AST_DIV_FORMULA: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        divisor_out == ((12'(prescale_in) + 12'h001) << ({1'b0, rate_in} + 4'h1)))
        else $error("baud divisor does not follow the formula");
    AST_HALF_TOGGLE: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        edge_out && run_in |=> sck_out != $past(sck_out))
        else $error("serial clock did not toggle at half period");
endmodule

// ==== core/spi_cfg_pkg.sv ====
// package: register map, field layout and shared types of the serial configuration slice
package spi_cfg_pkg;
    localparam logic [7:0] CTRL2_OFFSET = 8'h01;
    localparam logic [7:0] BAUD_OFFSET = 8'h02;
    localparam logic [7:0] CTRL1_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h03;
    localparam logic [7:0] DATA_HIGH_OFFSET = 8'h04;
    localparam logic [7:0] DATA_LOW_OFFSET = 8'h05;
    localparam logic [7:0] CTRL2_MASK = 8'h5B;
    localparam logic [7:0] BAUD_MASK = 8'h77;
    localparam logic [7:0] CTRL1_MASK = 8'h01;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam int WIDTH_POS = 6;
    localparam int MODE_FAULT_FLAG_EN_POS = 4;
    localparam int BIDIR_OE_POS = 3;
    localparam int WAIT_STOP_POS = 1;
    localparam int BIDIR_PIN_POS = 0;
    localparam int PRESCALE_LSB = 4;
    localparam int RATE_LSB = 0;
    localparam int MASTER_POS = 0;
    localparam int BYTE_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int DIV_BITS = 12;
    localparam logic [4:0] BITS_NARROW = 5'h08;
    localparam logic [4:0] BITS_WIDE = 5'h10;

    typedef struct packed {
        logic transfer_width_select;
        logic mode_fault_enable;
        logic bidir_output_enable;
        logic wait_mode_clock_stop;
        logic bidir_pin_control;
        logic [2:0] baud_prescale_field;
        logic [2:0] baud_rate_field;
        logic master_select;
    } cfg_t;

    typedef struct packed {
        logic mosi_oe;
        logic miso_oe;
        logic mosi_is_input;
        logic miso_is_input;
        logic ss_is_input;
        logic ss_used;
    } pin_dir_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } xfer_state_t;
endpackage

// ==== core/spi_width_pin_baud_config.sv ====
// configuration slice: width, slave-select, bidirectional pins, wait stop and baud clock
// Overview of operation
// - width bit picks 8 or 16 bits
// - master width change aborts to idle
// - mode fault enable governs master select pin
// - slave select pin always input in slave
// - bidir output enable drives active pin buffer
// - master bidir output enable change aborts when pin control is 1
// - wait stop bit halts serial clock
// - pin control 0 means normal pins
// - pin control 1 uses single pin
// - divisor is (prescale+1) times 2^(rate+1)
// - bit rate is bus clock over divisor
// - master baud field change aborts
// - registers always accessible, reserved bits fixed
// - master bit selects mode; switch idles
//
// The APB register port was chosen for this implementation.
module spi_width_pin_baud_config (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic WAIT_MODE_IN,
    input wire logic START_IN,
    input wire logic SS_IN,
    output logic SS_USED_OUT,
    output logic MOSI_OE_OUT,
    output logic MISO_OE_OUT,
    output logic MOSI_IS_INPUT_OUT,
    output logic MISO_IS_INPUT_OUT,
    output logic SCK_OUT,
    output logic SCK_OE_OUT,
    output logic BUSY_OUT,
    output logic FORCE_IDLE_OUT,
    output logic MODE_FAULT_OUT,
    output logic [4:0] XFER_BITS_OUT,
    output logic [11:0] DIVISOR_OUT
);
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] baud;
    spi_cfg_pkg::cfg_t cfg;
    spi_cfg_pkg::pin_dir_t pins;
    spi_cfg_pkg::xfer_state_t state;
    spi_cfg_pkg::xfer_state_t next_state;
    logic [7:0] wr_byte;
    logic access;
    logic wr_ctrl1;
    logic wr_ctrl2;
    logic wr_baud;
    logic mapped;
    logic abort;
    logic ss_meta;
    logic ss_sync;
    logic run;
    logic sck_edge;
    logic sck_int;
    logic [5:0] edge_count;
    logic [5:0] edge_target;
    logic [11:0] divisor;

    // package offsets are word indices; each register owns one aligned 32-bit word
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] idx);
        reg_hit = (a == {idx[5:0], 2'b00});
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = reg_hit(a, spi_cfg_pkg::CTRL1_OFFSET) ||
                    reg_hit(a, spi_cfg_pkg::CTRL2_OFFSET) ||
                    reg_hit(a, spi_cfg_pkg::BAUD_OFFSET) ||
                    reg_hit(a, spi_cfg_pkg::STATUS_OFFSET);
    endfunction

    assign access = PSEL_IN && PENABLE_IN;
    assign wr_byte = PWDATA_IN[7:0];
    assign mapped = is_mapped(PADDR_IN);
    assign wr_ctrl1 = access && PWRITE_IN && reg_hit(PADDR_IN, spi_cfg_pkg::CTRL1_OFFSET);
    assign wr_ctrl2 = access && PWRITE_IN && reg_hit(PADDR_IN, spi_cfg_pkg::CTRL2_OFFSET);
    assign wr_baud = access && PWRITE_IN && reg_hit(PADDR_IN, spi_cfg_pkg::BAUD_OFFSET);
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access && !mapped;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ctrl1 <= spi_cfg_pkg::CTRL1_RESET;
        end else if (wr_ctrl1) begin
            ctrl1 <= wr_byte & spi_cfg_pkg::CTRL1_MASK;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ctrl2 <= spi_cfg_pkg::CTRL2_RESET;
        end else if (wr_ctrl2) begin
            ctrl2 <= wr_byte & spi_cfg_pkg::CTRL2_MASK;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            baud <= spi_cfg_pkg::BAUD_RESET;
        end else if (wr_baud) begin
            baud <= wr_byte & spi_cfg_pkg::BAUD_MASK;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            case (PADDR_IN)
                {spi_cfg_pkg::CTRL1_OFFSET[5:0], 2'b00}: PRDATA_OUT <= {24'h000000, ctrl1};
                {spi_cfg_pkg::CTRL2_OFFSET[5:0], 2'b00}: PRDATA_OUT <= {24'h000000, ctrl2};
                {spi_cfg_pkg::BAUD_OFFSET[5:0], 2'b00}: PRDATA_OUT <= {24'h000000, baud};
                {spi_cfg_pkg::STATUS_OFFSET[5:0], 2'b00}: begin
                    PRDATA_OUT <= {24'h000000, 6'h00, MODE_FAULT_OUT, BUSY_OUT};
                end
                default: PRDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        cfg.transfer_width_select = ctrl2[spi_cfg_pkg::WIDTH_POS];
        cfg.mode_fault_enable = ctrl2[spi_cfg_pkg::MODE_FAULT_FLAG_EN_POS];
        cfg.bidir_output_enable = ctrl2[spi_cfg_pkg::BIDIR_OE_POS];
        cfg.wait_mode_clock_stop = ctrl2[spi_cfg_pkg::WAIT_STOP_POS];
        cfg.bidir_pin_control = ctrl2[spi_cfg_pkg::BIDIR_PIN_POS];
        cfg.baud_prescale_field = baud[spi_cfg_pkg::PRESCALE_LSB +: 3];
        cfg.baud_rate_field = baud[spi_cfg_pkg::RATE_LSB +: 3];
        cfg.master_select = ctrl1[spi_cfg_pkg::MASTER_POS];
    end

    // only writes that really change a field abort; rewriting the same value is harmless
    always_comb begin
        abort = 1'b0;
        if (wr_ctrl1 && (wr_byte[spi_cfg_pkg::MASTER_POS] != cfg.master_select)) begin
            abort = 1'b1;
        end
        if (cfg.master_select && wr_ctrl2) begin
            if (wr_byte[spi_cfg_pkg::WIDTH_POS] != cfg.transfer_width_select) begin
                abort = 1'b1;
            end
            if (wr_byte[spi_cfg_pkg::MODE_FAULT_FLAG_EN_POS] != cfg.mode_fault_enable) begin
                abort = 1'b1;
            end
            if (wr_byte[spi_cfg_pkg::BIDIR_PIN_POS] != cfg.bidir_pin_control) begin
                abort = 1'b1;
            end
            if (cfg.bidir_pin_control &&
                (wr_byte[spi_cfg_pkg::BIDIR_OE_POS] != cfg.bidir_output_enable)) begin
                abort = 1'b1;
            end
        end
        if (cfg.master_select && wr_baud && ((wr_byte & spi_cfg_pkg::BAUD_MASK) != baud)) begin
            abort = 1'b1;
        end
    end

    always_comb begin
        pins.ss_used = !cfg.master_select || cfg.mode_fault_enable;
        pins.ss_is_input = !cfg.master_select || cfg.mode_fault_enable;
        if (!cfg.bidir_pin_control) begin
            pins.mosi_oe = cfg.master_select;
            pins.miso_oe = !cfg.master_select;
            pins.mosi_is_input = !cfg.master_select;
            pins.miso_is_input = cfg.master_select;
        end else begin
            pins.mosi_oe = cfg.master_select && cfg.bidir_output_enable;
            pins.miso_oe = !cfg.master_select && cfg.bidir_output_enable;
            pins.mosi_is_input = cfg.master_select;
            pins.miso_is_input = !cfg.master_select;
        end
    end

    assign SS_USED_OUT = pins.ss_used;
    assign MOSI_OE_OUT = pins.mosi_oe;
    assign MISO_OE_OUT = pins.miso_oe;
    assign MOSI_IS_INPUT_OUT = pins.mosi_is_input;
    assign MISO_IS_INPUT_OUT = pins.miso_is_input;
    assign XFER_BITS_OUT = cfg.transfer_width_select ? spi_cfg_pkg::BITS_WIDE :
                                                       spi_cfg_pkg::BITS_NARROW;

    always_ff @(posedge CLK_IN) begin
        ss_meta <= SS_IN;
    end

    always_ff @(posedge CLK_IN) begin
        ss_sync <= ss_meta;
    end

    // mode fault: a master that watches its select pin sees it pulled low
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || !cfg.master_select) begin
            MODE_FAULT_OUT <= 1'b0;
        end else if (cfg.mode_fault_enable && !ss_sync) begin
            MODE_FAULT_OUT <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            spi_cfg_pkg::ST_IDLE: begin
                if (START_IN && cfg.master_select && !MODE_FAULT_OUT) begin
                    next_state = spi_cfg_pkg::ST_RUN;
                end
            end
            spi_cfg_pkg::ST_RUN: begin
                if (WAIT_MODE_IN && cfg.wait_mode_clock_stop) begin
                    next_state = spi_cfg_pkg::ST_HOLD;
                end else if (sck_edge && edge_count == edge_target) begin
                    next_state = spi_cfg_pkg::ST_IDLE;
                end
            end
            spi_cfg_pkg::ST_HOLD: begin
                if (!WAIT_MODE_IN) begin
                    next_state = spi_cfg_pkg::ST_RUN;
                end
            end
            default: next_state = spi_cfg_pkg::ST_IDLE;
        endcase
        if (abort || MODE_FAULT_OUT) begin
            next_state = spi_cfg_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state <= spi_cfg_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // a hold keeps the edge count so the frame resumes where it stopped
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || state == spi_cfg_pkg::ST_IDLE) begin
            edge_count <= 6'h01;
        end else if (sck_edge) begin
            edge_count <= edge_count + 6'h01;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            FORCE_IDLE_OUT <= 1'b0;
        end else begin
            FORCE_IDLE_OUT <= abort;
        end
    end

    assign edge_target = {XFER_BITS_OUT, 1'b0};
    assign run = (state == spi_cfg_pkg::ST_RUN);
    assign BUSY_OUT = (state != spi_cfg_pkg::ST_IDLE);
    assign SCK_OUT = sck_int;
    assign SCK_OE_OUT = cfg.master_select;
    assign DIVISOR_OUT = divisor;

    spi_baud_gen baud_gen (
        .CLK_IN(CLK_IN),
        .SRST_IN(SRST_IN),
        .run_in(run),
        .prescale_in(cfg.baud_prescale_field),
        .rate_in(cfg.baud_rate_field),
        .divisor_out(divisor),
        .sck_out(sck_int),
        .edge_out(sck_edge)
    );

    AST_WIDTH_BITS: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        XFER_BITS_OUT == (ctrl2[spi_cfg_pkg::WIDTH_POS] ? 5'h10 : 5'h08))
        else $error("transfer bit count does not match width bit");
    AST_WIDTH_ABORT: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        cfg.master_select && wr_ctrl2 && wr_byte[6] != ctrl2[6] |=> !BUSY_OUT)
        else $error("width change did not force idle");
    AST_SS_UNUSED: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        cfg.master_select && !cfg.mode_fault_enable
        |-> !SS_USED_OUT ##1 (!MODE_FAULT_OUT || $past(MODE_FAULT_OUT)))
        else $error("select pin used with fault detection off");
    AST_SS_SLAVE_IN: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !cfg.master_select |-> pins.ss_is_input)
        else $error("select pin not input in slave mode");
    AST_BIDIR_OE: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        ctrl2[0] |-> MOSI_OE_OUT == (ctrl1[0] && ctrl2[3])
        && MISO_OE_OUT == (!ctrl1[0] && ctrl2[3]))
        else $error("unused pin driven in single-wire mode");
    AST_OE_ABORT: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        cfg.master_select && cfg.bidir_pin_control && wr_ctrl2 && wr_byte[3] != ctrl2[3]
        |=> FORCE_IDLE_OUT && !BUSY_OUT)
        else $error("output enable change did not abort");
    AST_WAIT_STOP: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        run && WAIT_MODE_IN && cfg.wait_mode_clock_stop ##1 WAIT_MODE_IN |-> !run [*2])
        else $error("serial clock kept running in wait mode");
    AST_NORMAL_PINS: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !cfg.bidir_pin_control |-> MOSI_OE_OUT == cfg.master_select
        && MISO_OE_OUT == !cfg.master_select)
        else $error("normal pin directions wrong");
    AST_BAUD_ABORT: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        cfg.master_select && wr_baud && (wr_byte & 8'h77) != baud |=> !BUSY_OUT)
        else $error("baud change did not abort");
    AST_RESERVED: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (ctrl2 & ~8'h5B) == 8'h00 && (baud & ~8'h77) == 8'h00)
        else $error("reserved bit became set");
    AST_MODE_SWITCH: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        $changed(cfg.master_select) |-> !BUSY_OUT)
        else $error("mode switch did not idle");

    COV_FRAME: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        run ##1 !BUSY_OUT);
    COV_HOLD: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        state == spi_cfg_pkg::ST_HOLD ##1 run);
    COV_ABORT: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        run && abort);
    COV_FAULT: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        $rose(MODE_FAULT_OUT));
endmodule

// ==== test/spi_far_side.sv ====
// far-side serial device: drives the select line and counts serial clock rises
module spi_far_side (
    input wire logic clk_in,
    input wire logic sck_in,
    input wire logic select_n_in,
    output logic ss_n_out,
    output int rises_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q = 1'b0;
    int count = 0;
    // select is a plain level; the unit synchronises it itself
    assign ss_n_out = select_n_in;
    assign rises_out = count;
    always @(posedge clk_in) begin
        sck_q <= sck_in;
        if (sck_in && !sck_q) count <= count + 1;
    end
endmodule

// ==== test/tb_top.sv ====
// bench for the serial configuration slice: apb tasks, frames, aborts, pin table
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic wait_mode = 1'b0, start = 1'b0, sel_n = 1'b1, seen, errq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, ss, ss_used, mosi_oe, miso_oe, mosi_in, miso_in;
    logic sck, sck_oe, busy, fidle, mfault;
    logic [4:0] bits;
    logic [11:0] div;
    logic [5:0] pins;
    int rises, tog, bad_count = 0, tests_run = 0;

    spi_width_pin_baud_config i_spi_width_pin_baud_config (.CLK_IN(clk), .SRST_IN(srst),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .WAIT_MODE_IN(wait_mode), .START_IN(start), .SS_IN(ss), .SS_USED_OUT(ss_used),
        .MOSI_OE_OUT(mosi_oe), .MISO_OE_OUT(miso_oe), .MOSI_IS_INPUT_OUT(mosi_in),
        .MISO_IS_INPUT_OUT(miso_in), .SCK_OUT(sck), .SCK_OE_OUT(sck_oe), .BUSY_OUT(busy),
        .FORCE_IDLE_OUT(fidle), .MODE_FAULT_OUT(mfault), .XFER_BITS_OUT(bits),
        .DIVISOR_OUT(div));
    spi_far_side i_spi_far_side (.clk_in(clk), .sck_in(sck), .select_n_in(sel_n),
        .ss_n_out(ss), .rises_out(rises));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        // callers pass the register index; every register sits on its own word
        paddr <= {a[5:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdata, {24'h0, exp}, "read");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic go();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic toggles(input int n);
        logic prev;
        tog = 0;
        prev = sck;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (sck !== prev) tog++;
            prev = sck;
        end
    endtask

    // counts clock rises per frame and the spacing of the first two rises
    task automatic frame(input int nbits, input int d);
        int n, first, per, r0;
        r0 = rises;
        first = -1;
        per = 0;
        go();
        for (n = 0; n < 20000 && !(n > 2 && busy === 1'b0); n++) begin
            @(posedge clk);
            #1;
            if (rises == r0 + 1 && first < 0) first = n;
            if (rises == r0 + 2 && per == 0) per = n - first;
        end
        chk(32'(rises - r0), 32'(nbits), "clock rises");
        chk(32'(per), 32'(d), "bit period");
    endtask

    task automatic abort_case(input logic [7:0] c2, input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, spi_cfg_pkg::CTRL1_OFFSET, 8'h01);
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, c2);
        apb(1'b1, spi_cfg_pkg::BAUD_OFFSET, 8'h10);
        go();
        cyc(6);
        chk(32'(busy), 32'h1, "busy before abort");
        apb(1'b1, a, v);
        #1;
        seen = fidle;
        repeat (2) begin
            @(posedge clk);
            #1;
            seen = seen | fidle;
        end
        chk(32'({seen, busy}), 32'h2, "abort to idle");
        cyc(40);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(50 * 40000);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(spi_cfg_pkg::CTRL1_OFFSET, 8'h00);
        rd(spi_cfg_pkg::CTRL2_OFFSET, 8'h00);
        rd(spi_cfg_pkg::BAUD_OFFSET, 8'h00);
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, 8'hFF);
        rd(spi_cfg_pkg::CTRL2_OFFSET, spi_cfg_pkg::CTRL2_MASK);
        apb(1'b1, spi_cfg_pkg::BAUD_OFFSET, 8'hFF);
        rd(spi_cfg_pkg::BAUD_OFFSET, spi_cfg_pkg::BAUD_MASK);
        apb(1'b1, 8'h07, 8'hFF);
        chk(32'(errq), 32'h1, "unmapped error");
        rd(8'h07, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 64; i++) begin
            apb(1'b1, spi_cfg_pkg::BAUD_OFFSET, {1'b0, 3'(i >> 3), 1'b0, 3'(i)});
            #1;
            chk(32'(div), ((i >> 3) + 1) << ((i & 7) + 1), "divisor");
        end
        $display("test divisor done");
        for (int i = 0; i < 16; i++) begin
            // slave keeps its select asserted so a selected slave may drive
            @(posedge clk);
            sel_n <= i[3];
            apb(1'b1, spi_cfg_pkg::CTRL1_OFFSET, {7'h0, i[3]});
            apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, {3'h0, i[2], i[1], 2'h0, i[0]});
            cyc(4);
            if (i[3])
                pins = {i[2], i[0] ? i[1] : 1'b1, 1'b0, i[0], !i[0], 1'b1};
            else
                pins = {1'b1, 1'b0, i[0] ? i[1] : 1'b1, !i[0], i[0], 1'b0};
            rdata = 32'({ss_used, mosi_oe, miso_oe, mosi_in, miso_in, sck_oe});
            chk(rdata, 32'(pins), "pins");
        end
        $display("test pins done");
        sel_n <= 1'b1;
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, 8'h00);
        apb(1'b1, spi_cfg_pkg::BAUD_OFFSET, 8'h10);
        #1;
        chk(32'(bits), 32'd8, "width");
        frame(8, 4);
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, 8'h40);
        #1;
        chk(32'(bits), 32'd16, "width");
        frame(16, 4);
        apb(1'b1, spi_cfg_pkg::BAUD_OFFSET, 8'h21);
        frame(16, 12);
        $display("test frames done");
        abort_case(8'h00, spi_cfg_pkg::CTRL2_OFFSET, 8'h40);
        abort_case(8'h00, spi_cfg_pkg::CTRL2_OFFSET, 8'h10);
        abort_case(8'h00, spi_cfg_pkg::CTRL2_OFFSET, 8'h01);
        abort_case(8'h01, spi_cfg_pkg::CTRL2_OFFSET, 8'h09);
        abort_case(8'h00, spi_cfg_pkg::BAUD_OFFSET, 8'h11);
        abort_case(8'h00, spi_cfg_pkg::BAUD_OFFSET, 8'h00);
        abort_case(8'h00, spi_cfg_pkg::CTRL1_OFFSET, 8'h00);
        $display("test aborts done");
        apb(1'b1, spi_cfg_pkg::CTRL1_OFFSET, 8'h01);
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, 8'h02);
        go();
        cyc(3);
        @(posedge clk);
        wait_mode <= 1'b1;
        cyc(2);
        toggles(20);
        chk(32'(tog), 32'd0, "clock held in wait");
        chk(32'(busy), 32'h1, "frame held in wait");
        @(posedge clk);
        wait_mode <= 1'b0;
        cyc(1);
        toggles(8);
        chk(32'(tog), 32'd4, "clock resumes");
        cyc(60);
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, 8'h00);
        go();
        cyc(3);
        @(posedge clk);
        wait_mode <= 1'b1;
        cyc(1);
        toggles(8);
        chk(32'(tog), 32'd4, "clock runs in wait");
        @(posedge clk);
        wait_mode <= 1'b0;
        cyc(60);
        $display("test wait done");
        apb(1'b1, spi_cfg_pkg::CTRL2_OFFSET, 8'h10);
        sel_n <= 1'b0;
        cyc(6);
        chk(32'(mfault), 32'h1, "mode fault");
        rd(spi_cfg_pkg::STATUS_OFFSET, 8'h02);
        apb(1'b1, spi_cfg_pkg::CTRL1_OFFSET, 8'h00);
        cyc(2);
        chk(32'(mfault), 32'h0, "fault cleared");
        $display("test fault done");
        end_of_test();
    end
endmodule
